//--- verif/div_inc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module div_inc_monitor
  import div_inc_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // request side
  input wire logic        start,
  input wire logic [15:0] op_addr,
  input wire cpu_regs_t   regs_in,
  input wire logic [7:0]  rdata,
  // block outputs
  input wire logic        bus_valid,
  input wire bus_cycle_t  bus_out,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        illegal,
  input wire cpu_regs_t   regs_out
);
  logic        busy_reg;
  logic        div_reg;
  logic [5:0]  cnt_reg;
  cpu_regs_t   regs_reg;
  logic [15:0] op_reg;
  logic        take1;
  logic        divop;
  assign take1 = busy && !busy_reg;
  assign divop = take1 && (rdata == 8'h03 || rdata == 8'h02);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // first busy cycle and idle read run length
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      div_reg  <= 1'b0;
      cnt_reg  <= 6'h00;
    end else begin
      busy_reg <= busy;
      if (take1) div_reg <= divop;
      cnt_reg <= (bus_valid && bus_out.rw && bus_out.addr == 16'hffff) ? cnt_reg + 6'h01 : 6'h00;
    end
  end
  // operands as taken
  always_ff @(posedge clk_sys) begin
    if (start && !busy) begin
      regs_reg <= regs_in;
      op_reg   <= op_addr;
    end
  end
  wr_after_idle_a: assert property (bus_valid && !bus_out.rw |->
    $past(bus_out.addr) == 16'hffff && $past(bus_out.rw)) else $error("write without idle read");
  wr_same_addr_a: assert property (bus_valid && !bus_out.rw |->
    bus_out.addr == $past(bus_out.addr, 2)) else $error("write address differs");
  div_idle_count_a: assert property (div_reg && $fell(bus_valid) |->
    cnt_reg == 6'd39) else $error("divide idle read count wrong");
  div_latency_a: assert property (divop |-> ##42 done && !illegal)
    else $error("divide length wrong");
  div_carry_a: assert property (divop |-> ##42
    regs_out.condition_code_reg[0] == (regs_reg.index_reg_x == 16'h0000)) else $error("divide carry");
  inc_ovf_a: assert property (take1 && rdata == 8'h4c |-> ##3 done &&
    regs_out.acc_a == regs_reg.acc_a + 8'h01 &&
    regs_out.condition_code_reg[1] == (regs_reg.acc_a == 8'h7f) &&
    regs_out.condition_code_reg[0] == regs_reg.condition_code_reg[0]) else $error("add one a");
  inc_b_flags_a: assert property (take1 && rdata == 8'h5c |-> ##3 done &&
    regs_out.acc_b == regs_reg.acc_b + 8'h01 &&
    regs_out.condition_code_reg[3] == regs_out.acc_b[7] &&
    regs_out.condition_code_reg[2] == (regs_out.acc_b == 8'h00)) else $error("add one b");
  sp_bump_a: assert property (take1 && rdata == 8'h31 |-> ##1 bus_out.addr == op_reg + 16'h0001
    ##1 (bus_valid && bus_out.rw && bus_out.addr == regs_reg.stack_pointer) ##2 (done &&
    regs_out.stack_pointer == regs_reg.stack_pointer + 16'h0001 &&
    regs_out.condition_code_reg == regs_reg.condition_code_reg)) else $error("stack bump");
endmodule : div_inc_monitor
bind divide_and_increment_execution div_inc_monitor mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .start(start), .op_addr(op_addr), .regs_in(regs_in), .rdata(rdata), .bus_valid(bus_valid),
  .bus_out(bus_out), .busy(busy), .done(done), .illegal(illegal), .regs_out(regs_out));
`default_nettype wire

//--- verif/divide_and_increment_execution_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin mismatches++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module divide_and_increment_execution_test
  import div_inc_pkg::*;
;
  logic        clk_sys, sys_rst, start, bus_valid, busy, done, illegal, ill_seen;
  logic [15:0] op_addr;
  logic [7:0]  rdata;
  cpu_regs_t   regs_in, regs_out, r;
  bus_cycle_t  bus_out;
  int          mismatches, tests_run;
  divide_and_increment_execution dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .start(start),
    .op_addr(op_addr), .regs_in(regs_in), .rdata(rdata), .bus_valid(bus_valid),
    .bus_out(bus_out), .busy(busy), .done(done), .illegal(illegal), .regs_out(regs_out));
  mem_model mem (.clk_sys(clk_sys), .bus_valid(bus_valid), .bus_out(bus_out), .rdata(rdata));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (illegal === 1'b1) ill_seen <= 1'b1;
  task automatic run(input logic [7:0] o1, o2, o3, input cpu_regs_t ri);
    int n;
    mem.mem[8'h00] = o1;
    mem.mem[8'h01] = o2;
    mem.mem[8'h02] = o3;
    regs_in = ri;
    start = 1'b1;
    @(posedge clk_sys);
    #1 start = 1'b0;
    n = 0;
    do begin @(posedge clk_sys); #1 n++; end while (done !== 1'b1 && n < 60);
    `CHK("done", 1'b1, done)
    r = regs_out;
  endtask : run
  task t_fractional_divide_op;
    run(8'h03, 8'h00, 8'h00, {16'h0001, 16'h0003, 16'h0, 16'h0, 8'h0f});
    `CHK("fq", 32'h5555_0001, {r.index_reg_x, r.acc_a, r.acc_b})
    `CHK("fcc", 3'b000, r.condition_code_reg[2:0])
    run(8'h03, 8'h00, 8'h00, {16'h0009, 16'h0005, 16'h0, 16'h0, 8'h00});
    `CHK("fov", 19'h7fffa, {r.index_reg_x, r.condition_code_reg[2:0]})
    run(8'h03, 8'h00, 8'h00, {16'h0005, 16'h0000, 16'h0, 16'h0, 8'h00});
    `CHK("fz", 19'h7fffb, {r.index_reg_x, r.condition_code_reg[2:0]})
  endtask : t_fractional_divide_op
  task t_integer_divide_op;
    run(8'h02, 8'h00, 8'h00, {16'h0064, 16'h0007, 16'h0, 16'h0, 8'h0e});
    `CHK("iq", 35'h0_0070_0010, {r.index_reg_x, r.acc_a, r.acc_b, r.condition_code_reg[2:0]})
    run(8'h02, 8'h00, 8'h00, {16'h0003, 16'h0007, 16'h0, 16'h0, 8'h00});
    `CHK("iz", 19'h00004, {r.index_reg_x, r.condition_code_reg[2:0]})
    run(8'h02, 8'h00, 8'h00, {16'h0003, 16'h0000, 16'h0, 16'h0, 8'h02});
    `CHK("i0", 18'h3fffd, {r.index_reg_x, r.condition_code_reg[1:0]})
  endtask : t_integer_divide_op
  task t_inc;
    run(8'h4c, 8'h00, 8'h00, {8'h7f, 8'h00, 16'h0, 16'h0, 16'h0, 8'h01});
    `CHK("ia", 12'h80b, {r.acc_a, r.condition_code_reg[3:0]})
    run(8'h5c, 8'h00, 8'h00, {8'h00, 8'hff, 16'h0, 16'h0, 16'h0, 8'h00});
    `CHK("ib", 12'h004, {r.acc_b, r.condition_code_reg[3:0]})
    mem.mem[8'h40] = 8'h7f;
    run(8'h7c, 8'h20, 8'h40, {8'h00, 8'h00, 16'h0, 16'h0, 16'h0, 8'h01});
    `CHK("ie", 28'h2040_80b, {mem.wr_addr, mem.wr_data, r.condition_code_reg[3:0]})
    mem.mem[8'h50] = 8'hff;
    run(8'h6c, 8'h50, 8'h00, {8'h00, 8'h00, 16'h3000, 16'h0, 16'h0, 8'h00});
    `CHK("ix", 28'h3050_004, {mem.wr_addr, mem.wr_data, r.condition_code_reg[3:0]})
    mem.mem[8'h60] = 8'h00;
    run(8'h18, 8'h6c, 8'h60, {8'h00, 8'h00, 16'h0, 16'h4000, 16'h0, 8'h0e});
    `CHK("iy", 28'h4060_010, {mem.wr_addr, mem.wr_data, r.condition_code_reg[3:0]})
  endtask : t_inc
  task t_misc;
    run(8'h31, 8'h00, 8'h00, {8'h00, 8'h00, 16'h0, 16'h0, 16'hffff, 8'h2f});
    `CHK("sp", 24'h0000_2f, {r.stack_pointer, r.condition_code_reg})
    ill_seen = 1'b0;
    run(8'h01, 8'h00, 8'h00, {8'h12, 8'h34, 16'h5678, 16'h9abc, 16'hdef0, 8'h05});
    `CHK("ill", {1'b1, 64'h1234_5678_9abc_def0, 8'h05}, {ill_seen, r})
    ill_seen = 1'b0;
    run(8'h18, 8'h4c, 8'h00, {8'h21, 8'h43, 16'h0, 16'h0, 16'h0, 8'h00});
    `CHK("ily", {1'b1, 8'h21}, {ill_seen, r.acc_a})
  endtask : t_misc
  task final_report;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial begin
    sys_rst = 1'b1;
    start = 1'b0;
    op_addr = 16'h1000;
    regs_in = '0;
    ill_seen = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    `CHK("rst", 3'b000, {busy, done, bus_valid})
    t_fractional_divide_op;
    t_integer_divide_op;
    t_inc;
    t_misc;
    final_report;
  end
  initial begin
    #100000;
    mismatches++;
    final_report;
  end
endmodule : divide_and_increment_execution_test
`default_nettype wire

//--- verif/mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mem_model
  import div_inc_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // bus from block
  input  wire logic       bus_valid,
  input  wire bus_cycle_t bus_out,
  output logic [7:0]      rdata
);
  logic [7:0]  mem [256];
  logic [7:0]  last_reg;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  // outside read cycles the line shows the inverse of the last byte
  assign rdata = (bus_valid && bus_out.rw) ? mem[bus_out.addr[7:0]] : ~last_reg;
  always @(posedge clk_sys) begin
    last_reg <= rdata;
    if (bus_valid && !bus_out.rw) begin
      mem[bus_out.addr[7:0]] <= bus_out.wdata;
      wr_addr <= bus_out.addr;
      wr_data <= bus_out.wdata;
    end
  end
endmodule : mem_model
`default_nettype wire

//--- verilog/div_inc_defs.svh
`ifndef DIV_INC_DEFS_SVH
`define DIV_INC_DEFS_SVH

// opcodes
`define OPC_FRACTIONAL_DIVIDE_OP_FRAC      8'h03
`define OPC_INTEGER_DIVIDE_OP_INT       8'h02
`define OPC_INC_ACC_A      8'h4c
`define OPC_INC_ACC_B      8'h5c
`define OPC_INC_EXT        8'h7c
`define OPC_INC_IDX        8'h6c
`define OPC_PREFIX_Y       8'h18
`define OPC_SP_BUMP        8'h31

// bus and datapath constants
`define IDLE_ADDR          16'hffff
`define ALL_ONES_16        16'hffff
`define OVF_INC_VALUE      8'h7f

// divide: cycles 3..41 are idle reads, 39 of them
`define DIV_IDLE_CYCLES    6'd39

// condition code bit positions (s x h i n z v c)
`define CCR_C_BIT          0
`define CCR_V_BIT          1
`define CCR_Z_BIT          2
`define CCR_N_BIT          3

`endif

//--- verilog/div_inc_pkg.sv
package div_inc_pkg;

  typedef enum logic [11:0] {
    ST_FETCH   = 12'h001,
    ST_NEXT    = 12'h002,
    ST_PREFIX  = 12'h004,
    ST_ADDR_HI = 12'h008,
    ST_ADDR_LO = 12'h010,
    ST_OFFSET  = 12'h020,
    ST_IDX_GAP = 12'h040,
    ST_RD_OPND = 12'h080,
    ST_MOD_GAP = 12'h100,
    ST_WR_BACK = 12'h200,
    ST_DIV_RUN = 12'h400,
    ST_SP_RD   = 12'h800
  } exec_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_FRACTIONAL_DIVIDE_OP = 3'h1,
    OP_INTEGER_DIVIDE_OP = 3'h2,
    OP_INCM = 3'h3,
    OP_INSP = 3'h4
  } op_kind_t;

  // memory bus cycle as driven by the block
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rw;
  } bus_cycle_t;

  // programmer-visible registers
  typedef struct packed {
    logic [7:0]  acc_a;
    logic [7:0]  acc_b;
    logic [15:0] index_reg_x;
    logic [15:0] index_reg_y;
    logic [15:0] stack_pointer;
    logic [7:0]  condition_code_reg;
  } cpu_regs_t;

endpackage : div_inc_pkg

//--- verilog/divide_and_increment_execution.sv
`timescale 1ns/100ps
`default_nettype none
`include "div_inc_defs.svh"

module divide_and_increment_execution
  import div_inc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // instruction start from the sequencer
  input  wire logic        start,
  input  wire logic [15:0] op_addr,
  input  wire cpu_regs_t   regs_in,
  // memory bus
  input  wire logic [7:0]  rdata,
  output logic             bus_valid,
  output bus_cycle_t       bus_out,
  // results
  output logic             busy,
  output logic             done,
  output logic             illegal,
  output cpu_regs_t        regs_out
);

  exec_state_t state_reg;
  op_kind_t    kind_reg;
  logic        pre_y_reg;
  logic [15:0] pc_reg;
  logic [15:0] ea_reg;
  logic [7:0]  opnd_reg;
  logic [5:0]  cnt_reg;
  cpu_regs_t   work_reg;

  // divide datapath: 32 by 16 divide and remainder computed combinationally with / and %
  logic [31:0] num_frac;
  logic [31:0] num_int;
  logic [31:0] q_frac;
  logic [31:0] q_int;
  logic [15:0] r_frac;
  logic [15:0] r_int;
  logic [15:0] d_val;
  logic [15:0] x_val;
  logic        x_zero;
  logic        frac_ovf;

  assign d_val    = {work_reg.acc_a, work_reg.acc_b};
  assign x_val    = work_reg.index_reg_x;
  assign x_zero   = (x_val == 16'h0000);
  assign frac_ovf = (x_val <= d_val);
  assign num_frac = {d_val, 16'h0000};
  assign num_int  = {16'h0000, d_val};
  assign q_frac   = x_zero ? 32'h0000_0000 : num_frac / {16'h0000, x_val};
  assign q_int    = x_zero ? 32'h0000_0000 : num_int / {16'h0000, x_val};
  assign r_frac   = x_zero ? d_val : 16'(num_frac % {16'h0000, x_val});
  assign r_int    = x_zero ? d_val : 16'(num_int % {16'h0000, x_val});

  // add-one datapath
  logic [7:0] inc_src;
  logic [7:0] inc_res;
  logic [7:0] cc_inc;

  always_comb begin
    inc_src = opnd_reg;
    inc_res = inc_src + 8'h01;
    cc_inc  = work_reg.condition_code_reg;
    cc_inc[`CCR_N_BIT] = inc_res[7];
    cc_inc[`CCR_Z_BIT] = (inc_res == 8'h00);
    cc_inc[`CCR_V_BIT] = (inc_src == `OVF_INC_VALUE);
  end

  // accumulator form of add-one: result goes to a register, not memory
  logic        acc_form_reg;
  logic        acc_b_sel_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_form_reg  <= 1'b0;
      acc_b_sel_reg <= 1'b0;
    end else if (state_reg == ST_PREFIX) begin
      acc_form_reg  <= (rdata == `OPC_INC_ACC_A) || (rdata == `OPC_INC_ACC_B);
      acc_b_sel_reg <= (rdata == `OPC_INC_ACC_B);
    end
  end

  // sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= ST_FETCH;
      kind_reg  <= OP_NONE;
      pre_y_reg <= 1'b0;
      pc_reg    <= 16'h0000;
      ea_reg    <= 16'h0000;
      opnd_reg  <= 8'h00;
      cnt_reg   <= 6'd0;
      work_reg  <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
      illegal   <= 1'b0;
      regs_out  <= '0;
      bus_valid <= 1'b0;
      bus_out   <= '{addr: 16'h0000, wdata: 8'h00, rw: 1'b1};
    end else begin
      done    <= 1'b0;
      illegal <= 1'b0;
      unique case (state_reg)
        ST_FETCH: begin
          bus_valid <= 1'b0;
          if (start && !busy) begin
            busy      <= 1'b1;
            work_reg  <= regs_in;
            pc_reg    <= op_addr;
            pre_y_reg <= 1'b0;
            bus_valid <= 1'b1;
            bus_out   <= '{addr: op_addr, wdata: 8'h00, rw: 1'b1};
            state_reg <= ST_PREFIX;
          end
        end
        ST_PREFIX: begin
          // opcode byte returned for the fetch just issued
          pc_reg  <= pc_reg + 16'h0001;
          bus_out <= '{addr: pc_reg + 16'h0001, wdata: 8'h00, rw: 1'b1};
          unique case (rdata)
            `OPC_FRACTIONAL_DIVIDE_OP_FRAC: begin
              kind_reg  <= OP_FRACTIONAL_DIVIDE_OP;
              state_reg <= ST_NEXT;
            end
            `OPC_INTEGER_DIVIDE_OP_INT: begin
              kind_reg  <= OP_INTEGER_DIVIDE_OP;
              state_reg <= ST_NEXT;
            end
            `OPC_INC_ACC_A, `OPC_INC_ACC_B: begin
              kind_reg  <= OP_INCM;
              opnd_reg  <= (rdata == `OPC_INC_ACC_A) ? work_reg.acc_a : work_reg.acc_b;
              ea_reg    <= {8'h00, rdata};
              state_reg <= ST_NEXT;
            end
            `OPC_INC_EXT: begin
              kind_reg  <= OP_INCM;
              state_reg <= ST_ADDR_HI;
            end
            `OPC_INC_IDX: begin
              kind_reg  <= OP_INCM;
              state_reg <= ST_OFFSET;
            end
            `OPC_PREFIX_Y: begin
              if (pre_y_reg) begin
                illegal   <= 1'b1;
                state_reg <= ST_MOD_GAP;
                kind_reg  <= OP_NONE;
              end else begin
                pre_y_reg <= 1'b1;
              end
            end
            `OPC_SP_BUMP: begin
              kind_reg  <= OP_INSP;
              state_reg <= ST_NEXT;
            end
            default: begin
              illegal   <= 1'b1;
              kind_reg  <= OP_NONE;
              state_reg <= ST_MOD_GAP;
            end
          endcase
          // prefix must be followed by the indexed opcode only
          if (pre_y_reg && rdata != `OPC_INC_IDX) begin
            illegal   <= 1'b1;
            kind_reg  <= OP_NONE;
            state_reg <= ST_MOD_GAP;
          end
        end
        ST_NEXT: begin
          // cycle 2 (read of op + 1) is on the bus now
          if (kind_reg == OP_INSP) begin
            bus_out   <= '{addr: work_reg.stack_pointer, wdata: 8'h00, rw: 1'b1};
            state_reg <= ST_SP_RD;
          end else if (kind_reg == OP_INCM) begin
            bus_valid <= 1'b0;
            state_reg <= ST_WR_BACK;
          end else begin
            bus_out   <= '{addr: `IDLE_ADDR, wdata: 8'h00, rw: 1'b1};
            cnt_reg   <= `DIV_IDLE_CYCLES;
            state_reg <= ST_DIV_RUN;
          end
        end
        ST_DIV_RUN: begin
          cnt_reg <= cnt_reg - 6'd1;
          if (cnt_reg == 6'd1) begin
            bus_valid <= 1'b0;
            work_reg.condition_code_reg[`CCR_C_BIT] <= x_zero;
            if (kind_reg == OP_FRACTIONAL_DIVIDE_OP) begin
              work_reg.index_reg_x <= (x_zero || frac_ovf) ? `ALL_ONES_16
                                                           : q_frac[15:0];
              {work_reg.acc_a, work_reg.acc_b} <= r_frac;
              work_reg.condition_code_reg[`CCR_Z_BIT] <=
                (!(x_zero || frac_ovf) && q_frac[15:0] == 16'h0000);
              work_reg.condition_code_reg[`CCR_V_BIT] <= frac_ovf;
            end else begin
              work_reg.index_reg_x <= x_zero ? `ALL_ONES_16 : q_int[15:0];
              {work_reg.acc_a, work_reg.acc_b} <= r_int;
              work_reg.condition_code_reg[`CCR_Z_BIT] <=
                (!x_zero && q_int[15:0] == 16'h0000);
              work_reg.condition_code_reg[`CCR_V_BIT] <= 1'b0;
            end
            state_reg <= ST_WR_BACK;
          end
        end
        ST_SP_RD: begin
          bus_valid <= 1'b0;
          work_reg.stack_pointer <= work_reg.stack_pointer + 16'h0001;
          state_reg <= ST_WR_BACK;
        end
        ST_ADDR_HI: begin
          // rdata is hh; issue op + 2
          ea_reg[15:8] <= rdata;
          pc_reg       <= pc_reg + 16'h0001;
          bus_out      <= '{addr: pc_reg + 16'h0001, wdata: 8'h00, rw: 1'b1};
          state_reg    <= ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          ea_reg[7:0] <= rdata;
          bus_out     <= '{addr: {ea_reg[15:8], rdata}, wdata: 8'h00, rw: 1'b1};
          state_reg   <= ST_RD_OPND;
        end
        ST_OFFSET: begin
          // rdata is ff; one idle read before the operand read
          ea_reg    <= (pre_y_reg ? work_reg.index_reg_y : work_reg.index_reg_x)
                       + {8'h00, rdata};
          bus_out   <= '{addr: `IDLE_ADDR, wdata: 8'h00, rw: 1'b1};
          state_reg <= ST_IDX_GAP;
        end
        ST_IDX_GAP: begin
          bus_out   <= '{addr: ea_reg, wdata: 8'h00, rw: 1'b1};
          state_reg <= ST_RD_OPND;
        end
        ST_RD_OPND: begin
          opnd_reg  <= rdata;
          bus_out   <= '{addr: `IDLE_ADDR, wdata: 8'h00, rw: 1'b1};
          state_reg <= ST_MOD_GAP;
        end
        ST_MOD_GAP: begin
          if (kind_reg == OP_INCM) begin
            bus_out   <= '{addr: ea_reg, wdata: inc_res, rw: 1'b0};
            work_reg.condition_code_reg <= cc_inc;
            state_reg <= ST_WR_BACK;
          end else begin
            bus_valid <= 1'b0;
            state_reg <= ST_WR_BACK;
          end
        end
        ST_WR_BACK: begin
          // final cycle over: publish registers
          bus_valid <= 1'b0;
          bus_out   <= '{addr: 16'h0000, wdata: 8'h00, rw: 1'b1};
          busy      <= 1'b0;
          done      <= 1'b1;
          if (kind_reg == OP_INCM && acc_form_reg) begin
            // accumulator form: result written to register only
            if (!acc_b_sel_reg) begin
              regs_out <= '{acc_a: inc_res, acc_b: work_reg.acc_b,
                            index_reg_x: work_reg.index_reg_x,
                            index_reg_y: work_reg.index_reg_y,
                            stack_pointer: work_reg.stack_pointer,
                            condition_code_reg: cc_inc};
            end else begin
              regs_out <= '{acc_a: work_reg.acc_a, acc_b: inc_res,
                            index_reg_x: work_reg.index_reg_x,
                            index_reg_y: work_reg.index_reg_y,
                            stack_pointer: work_reg.stack_pointer,
                            condition_code_reg: cc_inc};
            end
          end else begin
            regs_out <= work_reg;
          end
          state_reg <= ST_FETCH;
        end
        default: state_reg <= ST_FETCH;
      endcase
    end
  end

endmodule : divide_and_increment_execution
`default_nettype wire
